/* testbench/spi_master_model.sv */
// serial bus master model that drives the memory front end
module spi_master_model (
    output logic     sclk,
    output logic     mosi,
    output logic     csN,
    output logic     pauseN,
    output logic     guardN,
    input wire logic misoWire,
    input wire logic misoOe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] txBuf [0:7];
    logic [7:0] rxBuf [0:7];
    logic       oeSeen;
    logic       pauseOe;
    // select starts low so the first frame can be sent with no falling edge
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        csN = 1'b0;
        pauseN = 1'b1;
        guardN = 1'b1;
    end
    // ==========================================================
    // one frame; input sampled late in the high phase, 4 ns before the fall
    task automatic frame(input bit m3, input int n, input bit sel,
                         input int pAt, input bit ab);
        oeSeen = 1'b0;
        sclk = m3;
        if (sel) begin
            csN = 1'b1;
            #64 csN = 1'b0;
        end
        #32;
        for (int i = 0; i < 8 * n; i++) begin
            if (m3) sclk = 1'b0;
            mosi = txBuf[i / 8][7 - i % 8];
            if (i == pAt) begin
                pauseN = 1'b0;
                #40 pauseOe = misoOe;
                repeat (2) begin
                    mosi = ~mosi;
                    #32 sclk = 1'b1;
                    #32 sclk = 1'b0;
                end
                if (ab) begin
                    csN = 1'b1;
                    sclk = m3;
                    #64 pauseN = 1'b1;
                    return;
                end
                #32 pauseN = 1'b1;
                mosi = txBuf[i / 8][7 - i % 8];
                #32;
            end
            #32 sclk = 1'b1;
            #28 rxBuf[i / 8][7 - i % 8] = misoWire;
            oeSeen |= misoOe;
            #4;
            if (!m3) sclk = 1'b0;
        end
        #32 csN = 1'b1;
        mosi = ~mosi;
        sclk = m3;
        #64;
    endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the serial memory front end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, sclk, mosi, csN, pauseN, guardN;
    logic misoOut, misoOe, standby, active;
    wire  misoWire;
    int   errCount = 0;
    int   cmpCount = 0;
    int   seed = 67;
    int   pAt = -1;
    bit   ab = 1'b0;
    // undriven output floats, so a missing enable shows as z
    assign misoWire = misoOe ? misoOut : 1'bz;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    spi_eeprom_serial_frontend #(.FIFO_DEPTH(4))
        i_spi_eeprom_serial_frontend (
        .clk(clk), .reset(reset), .sclkPin(sclk), .mosiPin(mosi),
        .unitPickPinN(csN), .pausePinN(pauseN), .guardPinN(guardN),
        .misoOut(misoOut), .misoOe(misoOe), .standby(standby),
        .active(active));
    spi_master_model i_spi_master_model (
        .sclk(sclk), .mosi(mosi), .csN(csN), .pauseN(pauseN),
        .guardN(guardN), .misoWire(misoWire), .misoOe(misoOe));
    // ==========================================================
    // comparison and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t %s seen %h exp %h",
                     $time, what, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #500_000;
        errCount++;
        summarize();
    end
    // ==========================================================
    // frame helpers
    task automatic cmd(input bit m3, input int n, input logic [7:0] b0,
                       input logic [7:0] b1, input logic [7:0] b2);
        i_spi_master_model.txBuf[0] = b0;
        i_spi_master_model.txBuf[1] = b1;
        i_spi_master_model.txBuf[2] = b2;
        fork
            i_spi_master_model.frame(m3, n, 1'b1, pAt, ab);
            begin
                #140 check(active, 1, "active");
                check(standby, 0, "not standby");
            end
        join
        check(misoOe, 0, "oe deselected");
        check(active, 0, "inactive");
        // keep pin changes off the clock edge after this wait
        for (int k = 0; k < 200 && standby !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check(standby, 1, "standby");
    endtask
    // status write takes exactly one data byte
    task automatic wsr(input bit m3, input logic [7:0] v);
        cmd(m3, 1, 8'h06, 8'h00, 8'h00);
        cmd(m3, 2, 8'h01, v, 8'h00);
    endtask
    task automatic stat(input bit m3, input logic [7:0] mk, exp);
        cmd(m3, 2, 8'h05, 8'h5A, 8'h00);
        check(i_spi_master_model.rxBuf[1] & mk, exp & mk, "status");
    endtask
    task automatic rd1(input bit m3, input logic [7:0] op, hi, lo, exp);
        i_spi_master_model.txBuf[3] = $random(seed);
        cmd(m3, 4, op, hi, lo);
        check(i_spi_master_model.rxBuf[3], exp, "read byte");
    endtask
    task automatic wr1(input bit m3, input logic [7:0] op, hi, lo, v);
        cmd(m3, 1, 8'h06, 8'h00, 8'h00);
        i_spi_master_model.txBuf[3] = v;
        cmd(m3, 4, op, hi, lo);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] d [0:3];
        logic [9:0] a;
        bit         m3;
        logic [7:0] v;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        check(standby, 1, "standby at reset");
        check(misoOe, 0, "oe at reset");
        i_spi_master_model.txBuf[0] = 8'h05;
        i_spi_master_model.frame(1'b0, 2, 1'b0, -1, 1'b0);
        check(i_spi_master_model.oeSeen, 0, "no select edge");
        $display("test arming done");
        for (int t = 0; t < 6; t++) begin
            m3 = $random(seed);
            a = $random(seed);
            a[1:0] = 2'b00;
            for (int k = 0; k < 4; k++) begin
                d[k] = $random(seed);
                i_spi_master_model.txBuf[3 + k] = d[k];
            end
            cmd(m3, 1, 8'h06, 8'h00, 8'h00);
            cmd(m3, 7, 8'h02, {6'h00, a[9:8]}, a[7:0]);
            for (int k = 0; k < 4; k++) begin
                i_spi_master_model.txBuf[3 + k] = ~d[k];
            end
            cmd(!m3, 7, 8'h03, {6'h00, a[9:8]}, a[7:0]);
            for (int k = 0; k < 4; k++) begin
                check(i_spi_master_model.rxBuf[3 + k], d[k], "data");
            end
        end
        $display("test write read done");
        pAt = 28;
        rd1(m3, 8'h03, {6'h00, a[9:8]}, a[7:0], d[0]);
        check(i_spi_master_model.pauseOe, 0, "oe in pause");
        pAt = -1;
        $display("test pause done");
        wsr(m3, 8'h8C);
        stat(m3, 8'hFC, 8'h8C);
        wr1(m3, 8'h02, {6'h00, a[9:8]}, a[7:0], ~d[0]);
        rd1(!m3, 8'h03, {6'h00, a[9:8]}, a[7:0], d[0]);
        i_spi_master_model.guardN = 1'b0;
        wsr(m3, 8'h00);
        stat(m3, 8'hFC, 8'h8C);
        i_spi_master_model.guardN = 1'b1;
        wsr(m3, 8'h00);
        stat(m3, 8'hFC, 8'h00);
        $display("test guard done");
        cmd(m3, 1, 8'h06, 8'h00, 8'h00);
        stat(!m3, 8'hFF, 8'h02);
        cmd(m3, 1, 8'h04, 8'h00, 8'h00);
        stat(!m3, 8'hFF, 8'h00);
        cmd(m3, 1, 8'h06, 8'h00, 8'h00);
        pAt = 12;
        ab = 1'b1;
        cmd(m3, 2, 8'h01, 8'h0C, 8'h00);
        pAt = -1;
        ab = 1'b0;
        cmd(m3, 3, 8'hA5, 8'h05, 8'h00);
        check(i_spi_master_model.oeSeen, 0, "unknown code");
        stat(m3, 8'hFF, 8'h02);
        $display("test abort done");
        v = $random(seed);
        wr1(m3, 8'h82, 8'h00, 8'h11, v);
        rd1(!m3, 8'h83, 8'h00, 8'h11, v);
        wr1(m3, 8'h82, 8'h04, 8'h00, v);
        wr1(m3, 8'h82, 8'h00, 8'h11, ~v);
        rd1(!m3, 8'h83, 8'h00, 8'h11, v);
        $display("test id page done");
        summarize();
    end
endmodule

/* verilog/eeprom_array.sv */
// byte array: main locations plus identification page
`include "spi_eeprom_consts.svh"
module eeprom_array #(
    parameter int MAIN_DEPTH = `MAIN_DEPTH,
    parameter int ID_DEPTH   = `ID_DEPTH
) (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               rdBusy,
    stream_if.snk                  wrS,
    input wire logic [`ADDR_W-1:0] rdAddr,
    input wire logic               rdId,
    output logic [7:0]             rdData
);
    logic [7:0] cells [MAIN_DEPTH+ID_DEPTH];
    spi_eeprom_pkg::wr_word_s w;
    int wrIdx;
    int rdIdx;

    // reads own the port during read instructions; writes stall
    assign wrS.ready = !rdBusy;
    assign w = wrS.data;

    always_comb begin
        wrIdx = w.id ? MAIN_DEPTH + int'(w.addr[`ID_W-1:0]) : int'(w.addr);
        rdIdx = rdId ? MAIN_DEPTH + int'(rdAddr[`ID_W-1:0]) : int'(rdAddr);
    end

    always_ff @(posedge clk) begin
        if (wrS.valid && !rdBusy) begin
            cells[wrIdx] <= w.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdData <= 8'h00;
        end else begin
            rdData <= cells[rdIdx];
        end
    end
endmodule

/* verilog/spi_eeprom_consts.svh */
// constants of the serial memory front end
`ifndef SPI_EEPROM_CONSTS_SVH
`define SPI_EEPROM_CONSTS_SVH
// ==========================================================
// array geometry
`define ADDR_W     10
`define ID_W       5
`define MAIN_DEPTH 1024
`define ID_DEPTH   32
`define PAGE_W     5
`define FIFO_DEPTH 4
// ==========================================================
// instruction codes
`define INS_WREN 8'h06
`define INS_WRDI 8'h04
`define INS_RDSR 8'h05
`define INS_WRSR 8'h01
`define INS_READ 8'h03
`define INS_WRIT 8'h02
`define INS_RDID 8'h83
`define INS_WRID 8'h82
// ==========================================================
// status byte fields and reset value
`define SR_SRWD  7
`define SR_BPHI  3
`define SR_BPLO  2
`define SR_WEL   1
`define SR_WIP   0
`define SR_RESET 8'h00
`endif

/* verilog/spi_eeprom_pkg.sv */
// types shared by the serial memory front end
`include "spi_eeprom_consts.svh"
package spi_eeprom_pkg;
    typedef enum logic [2:0] {
        ST_CMD   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b010,
        ST_WAIT  = 3'b110
    } state_e;

    typedef struct packed {
        logic               id;
        logic [`ADDR_W-1:0] addr;
        logic [7:0]         data;
    } wr_word_s;
endpackage

/* verilog/spi_eeprom_serial_frontend.sv */
// serial slave front end of a byte-wide nonvolatile memory
`include "spi_eeprom_consts.svh"
module spi_eeprom_serial_frontend #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclkPin,
    input wire logic mosiPin,
    input wire logic unitPickPinN,
    input wire logic pausePinN,
    input wire logic guardPinN,
    output logic     misoOut,
    output logic     misoOe,
    output logic     standby,
    output logic     active
);
    // ==========================================================
    // declarations
    logic [2:0] sclkSh;
    logic [2:0] csSh;
    logic [1:0] holdSh;
    logic [1:0] mosiSh;
    logic [1:0] guardSh;
    logic sclkSync, sclkPrev, csSync, csPrev;
    logic holdSync, mosiSync, guardSync;
    logic armed_reg, hold_reg, sel, live, rise, fall;
    logic deselNow, byteDone, okEnd;
    spi_eeprom_pkg::state_e st_reg, st_next;
    logic [2:0] bitCnt_reg;
    logic [6:0] shiftIn_reg;
    logic [7:0] byteIn;
    logic [7:0] cmd_reg;
    logic addrHi_reg, lockSel_reg;
    logic [`ADDR_W-1:0] addr_reg;
    logic wel_reg, srwd_reg, bpHi_reg, bpLo_reg;
    logic srPend_reg, lockPend_reg, idLocked_reg;
    logic [7:0] srData_reg;
    logic [7:0] status;
    logic idCmd, readCmd, writeCmd, prot, pushOk;
    logic [2:0] outCnt_reg;
    logic [6:0] outShift_reg;
    logic miso_reg, drv_reg;
    logic [7:0] curByte, memData;
    logic wip;
    localparam int WW = $bits(spi_eeprom_pkg::wr_word_s);
    stream_if #(.W(WW)) pushIf ();
    stream_if #(.W(WW)) drainIf ();

    // ==========================================================
    // pin synchronisers; edges come from the second and third flops
    always_ff @(posedge clk) begin
        if (reset) begin
            sclkSh <= 3'b000;
            csSh <= 3'b000; // a pin held low from the start shows no fall
            holdSh <= 2'b11;
            mosiSh <= 2'b00;
            guardSh <= 2'b11;
        end else begin
            sclkSh <= {sclkSh[1:0], sclkPin};
            csSh <= {csSh[1:0], unitPickPinN};
            holdSh <= {holdSh[0], pausePinN};
            mosiSh <= {mosiSh[0], mosiPin};
            guardSh <= {guardSh[0], guardPinN};
        end
    end
    assign sclkSync = sclkSh[1];
    assign sclkPrev = sclkSh[2];
    assign csSync = csSh[1];
    assign csPrev = csSh[2];
    assign holdSync = holdSh[1];
    assign mosiSync = mosiSh[1];
    assign guardSync = guardSh[1];

    // ==========================================================
    // selection and pause
    always_ff @(posedge clk) begin
        if (reset) begin
            armed_reg <= 1'b0;
        end else if (!csSync && csPrev) begin
            armed_reg <= 1'b1;
        end
    end

    // a pause edge seen with the clock high waits for the clock low
    always_ff @(posedge clk) begin
        if (reset || csSync || !armed_reg) begin
            hold_reg <= 1'b0;
        end else if (!hold_reg && !holdSync && !sclkSync) begin
            hold_reg <= 1'b1;
        end else if (hold_reg && holdSync && !sclkSync) begin
            hold_reg <= 1'b0;
        end
    end

    // either clock idle level is fine: only edges are used
    assign sel = !csSync && armed_reg;
    assign live = sel && !hold_reg;
    assign rise = live && sclkSync && !sclkPrev;
    assign fall = live && !sclkSync && sclkPrev;
    assign deselNow = csSync && !csPrev && armed_reg;
    assign byteIn = {shiftIn_reg, mosiSync};
    assign byteDone = rise && (bitCnt_reg == 3'd7);
    // a pause at deselect aborts; a ragged bit count also refuses
    assign okEnd = deselNow && !hold_reg && (bitCnt_reg == 3'd0);

    // ==========================================================
    // command decoding
    assign idCmd = (cmd_reg == `INS_RDID) || (cmd_reg == `INS_WRID);
    assign readCmd = (cmd_reg == `INS_READ) || (cmd_reg == `INS_RDID);
    assign writeCmd = (cmd_reg == `INS_WRIT) || (cmd_reg == `INS_WRID)
        || (cmd_reg == `INS_WRSR);

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            spi_eeprom_pkg::ST_CMD: begin
                if (byteIn == `INS_RDSR) begin
                    st_next = spi_eeprom_pkg::ST_RDATA;
                end else if (byteIn == `INS_WRSR) begin
                    st_next = spi_eeprom_pkg::ST_WDATA;
                end else if (byteIn == `INS_READ || byteIn == `INS_WRIT
                    || byteIn == `INS_RDID || byteIn == `INS_WRID) begin
                    st_next = spi_eeprom_pkg::ST_ADDR;
                end else begin
                    st_next = spi_eeprom_pkg::ST_WAIT;
                end
            end
            spi_eeprom_pkg::ST_ADDR: begin
                if (addrHi_reg) begin
                    st_next = readCmd ? spi_eeprom_pkg::ST_RDATA
                                      : spi_eeprom_pkg::ST_WDATA;
                end
            end
            spi_eeprom_pkg::ST_WDATA: st_next = spi_eeprom_pkg::ST_WDATA;
            spi_eeprom_pkg::ST_RDATA: st_next = spi_eeprom_pkg::ST_RDATA;
            spi_eeprom_pkg::ST_WAIT:  st_next = spi_eeprom_pkg::ST_WAIT;
            default:                  st_next = spi_eeprom_pkg::ST_WAIT;
        endcase
    end

    // bit position survives a pause since shifting only moves on rise
    always_ff @(posedge clk) begin
        if (reset || csSync) begin
            st_reg <= spi_eeprom_pkg::ST_CMD;
            bitCnt_reg <= 3'd0;
            shiftIn_reg <= 7'h00;
        end else if (rise) begin
            bitCnt_reg <= bitCnt_reg + 3'd1;
            shiftIn_reg <= byteIn[6:0];
            if (bitCnt_reg == 3'd7) begin
                st_reg <= st_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_reg <= 8'h00;
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_CMD) begin
            cmd_reg <= byteIn;
        end
    end

    // ==========================================================
    // address handling
    always_ff @(posedge clk) begin
        if (reset || csSync) begin
            addrHi_reg <= 1'b0;
            lockSel_reg <= 1'b0;
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_ADDR) begin
            addrHi_reg <= 1'b1;
            if (!addrHi_reg) begin
                lockSel_reg <= byteIn[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_reg <= '0;
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_ADDR) begin
            if (!addrHi_reg) begin
                addr_reg[`ADDR_W-1:8] <= byteIn[`ADDR_W-9:0];
            end else begin
                addr_reg[7:0] <= byteIn;
            end
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_WDATA) begin
            // page writes wrap inside the current page
            addr_reg[`PAGE_W-1:0] <= addr_reg[`PAGE_W-1:0] + 1'b1;
        end else if (fall && st_reg == spi_eeprom_pkg::ST_RDATA
            && outCnt_reg == 3'd0 && readCmd) begin
            addr_reg <= addr_reg + 1'b1;
        end
    end

    // ==========================================================
    // status byte, write latch, identification page lock
    always_ff @(posedge clk) begin
        if (reset) begin
            wel_reg <= 1'(`SR_RESET >> `SR_WEL);
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_CMD
            && byteIn == `INS_WREN) begin
            wel_reg <= 1'b1;
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_CMD
            && byteIn == `INS_WRDI) begin
            wel_reg <= 1'b0;
        end else if (okEnd && writeCmd
            && st_reg != spi_eeprom_pkg::ST_CMD) begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || csSync) begin
            srPend_reg <= 1'b0;
            srData_reg <= 8'h00;
            lockPend_reg <= 1'b0;
        end else if (byteDone && st_reg == spi_eeprom_pkg::ST_WDATA) begin
            if (cmd_reg == `INS_WRSR) begin
                srPend_reg <= wel_reg;
                srData_reg <= byteIn;
            end else if (cmd_reg == `INS_WRID && lockSel_reg) begin
                lockPend_reg <= wel_reg;
            end
        end
    end

    // guard low with the write-disable bit set freezes protection
    always_ff @(posedge clk) begin
        if (reset) begin
            srwd_reg <= 1'b0;
            bpHi_reg <= 1'b0;
            bpLo_reg <= 1'b0;
        end else if (okEnd && srPend_reg && !(srwd_reg && !guardSync)) begin
            srwd_reg <= srData_reg[`SR_SRWD];
            bpHi_reg <= srData_reg[`SR_BPHI];
            bpLo_reg <= srData_reg[`SR_BPLO];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            idLocked_reg <= 1'b0;
        end else if (okEnd && lockPend_reg) begin
            idLocked_reg <= 1'b1;
        end
    end

    always_comb begin
        status = 8'h00;
        status[`SR_SRWD] = srwd_reg;
        status[`SR_BPHI] = bpHi_reg;
        status[`SR_BPLO] = bpLo_reg;
        status[`SR_WEL] = wel_reg;
        status[`SR_WIP] = wip;
    end

    // ==========================================================
    // write path: bytes pass the fifo into the array
    always_comb begin
        unique case ({bpHi_reg, bpLo_reg})
            2'b00: prot = 1'b0;
            2'b01: prot = (addr_reg[`ADDR_W-1 -: 2] == 2'b11);
            2'b10: prot = addr_reg[`ADDR_W-1];
            2'b11: prot = 1'b1;
        endcase
    end

    assign pushOk = wel_reg && (((cmd_reg == `INS_WRIT) && !prot)
        || ((cmd_reg == `INS_WRID) && !lockSel_reg && !idLocked_reg));
    assign pushIf.valid = byteDone && st_reg == spi_eeprom_pkg::ST_WDATA
        && pushOk;
    assign pushIf.data = {idCmd, addr_reg, byteIn};
    assign wip = drainIf.valid;

    stream_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) wrFifo (
        .clk   (clk),
        .reset (reset),
        .inS   (pushIf),
        .outS  (drainIf)
    );

    eeprom_array array (
        .clk    (clk),
        .reset  (reset),
        .rdBusy (st_reg == spi_eeprom_pkg::ST_RDATA),
        .wrS    (drainIf),
        .rdAddr (addr_reg),
        .rdId   (idCmd),
        .rdData (memData)
    );

    // ==========================================================
    // read path
    assign curByte = (cmd_reg == `INS_RDSR) ? status : memData;

    always_ff @(posedge clk) begin
        if (reset || csSync) begin
            outCnt_reg <= 3'd0;
            outShift_reg <= 7'h00;
            miso_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else if (fall && st_reg == spi_eeprom_pkg::ST_RDATA) begin
            outCnt_reg <= outCnt_reg + 3'd1;
            drv_reg <= 1'b1;
            if (outCnt_reg == 3'd0) begin
                miso_reg <= curByte[7];
                outShift_reg <= curByte[6:0];
            end else begin
                miso_reg <= outShift_reg[6];
                outShift_reg <= {outShift_reg[5:0], 1'b0};
            end
        end
    end

    assign misoOut = miso_reg;
    assign misoOe = drv_reg && sel && !hold_reg;
    assign standby = !sel && !wip;
    assign active = sel;

    // ==========================================================
    // checks
    sequence s_read_load;
        fall && st_reg == spi_eeprom_pkg::ST_RDATA && outCnt_reg == 3'd0;
    endsequence

    sequence s_pause_on;
        $rose(hold_reg);
    endsequence

    a_desel_quiet: assert property (
        @(posedge clk) disable iff (reset) csSync |-> !misoOe)
        else $error("output driven while deselected");

    a_pause_quiet: assert property (
        @(posedge clk) disable iff (reset) hold_reg |-> !misoOe && !rise)
        else $error("activity during pause");

    a_out_on_fall: assert property (
        @(posedge clk) disable iff (reset || csSync)
        $changed(miso_reg) |-> $past(fall))
        else $error("output moved without falling edge");

    a_in_on_rise: assert property (
        @(posedge clk) disable iff (reset || csSync)
        $changed(bitCnt_reg) |-> $past(rise))
        else $error("bit count moved without rising edge");

    a_unarmed_idle: assert property (
        @(posedge clk) disable iff (reset)
        !armed_reg |-> st_reg == spi_eeprom_pkg::ST_CMD && !misoOe)
        else $error("traffic taken before first select edge");

    a_pause_entry: assert property (
        @(posedge clk) disable iff (reset)
        s_pause_on |-> $past(!sclkSync) && $past(!holdSync))
        else $error("pause entered with clock high");

    a_pause_keeps: assert property (
        @(posedge clk) disable iff (reset)
        s_pause_on ##0 (hold_reg && !csSync)[*3] |-> $stable(bitCnt_reg))
        else $error("bit position lost in pause");

    a_wait_stays: assert property (
        @(posedge clk) disable iff (reset)
        st_reg == spi_eeprom_pkg::ST_WAIT && !csSync |=>
        st_reg == spi_eeprom_pkg::ST_WAIT && !misoOe)
        else $error("left wait state while selected");

    a_first_msb: assert property (
        @(posedge clk) disable iff (reset || csSync)
        s_read_load |=> misoOe == !hold_reg && miso_reg == $past(curByte[7]))
        else $error("first read bit not the top bit");

    a_no_prot_wr: assert property (
        @(posedge clk) disable iff (reset)
        pushIf.valid && cmd_reg == `INS_WRIT |-> !prot && wel_reg)
        else $error("write into protected area");
endmodule

/* verilog/stream_fifo.sv */
// small synchronous fifo with valid/ready on both sides
module stream_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    stream_if.snk    inS,
    stream_if.src    outS
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] store [DEPTH];
    logic [AW:0]  wrPtr_reg;
    logic [AW:0]  rdPtr_reg;
    logic         full;
    logic         empty;

    assign empty = (wrPtr_reg == rdPtr_reg);
    assign full  = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) && !empty;
    assign inS.ready  = !full;
    assign outS.valid = !empty;
    assign outS.data  = store[rdPtr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (inS.valid && !full) begin
            store[wrPtr_reg[AW-1:0]] <= inS.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr_reg <= '0;
        end else if (inS.valid && !full) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdPtr_reg <= '0;
        end else if (outS.ready && !empty) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule

/* verilog/stream_if.sv */
// valid/ready word stream between internal modules
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
